// *** inc/dfcs_pkg.sv ***
// Package for the data flash command sequencer: codes, indices, layouts, timing.
// Assumes a single 100 MHz system clock and synchronous active-high reset.
package dfcs_pkg;
    localparam logic [7:0]  CMD_PROGRAM    = 8'h11;   // Word program command code
    localparam logic [7:0]  CMD_ERASE      = 8'h12;   // Sector erase command code
    localparam logic [2:0]  IDX_CMD        = 3'h0;    // Command and block select
    localparam logic [2:0]  IDX_ADDR       = 3'h1;    // Word address bits 15..0
    localparam logic [2:0]  IDX_DATA_FIRST = 3'h2;    // First data word
    localparam logic [2:0]  IDX_DATA_LAST  = 3'h5;    // Last data word
    localparam int          PARAM_DEPTH    = 6;       // Parameter words held
    localparam logic [6:0]  DF_BLOCK_SEL   = 7'h10;   // Block select of data flash
    localparam logic [15:0] DF_BASE        = 16'h0000; // First word address
    localparam logic [15:0] DF_LAST        = 16'h0fff; // Last byte address of block
    localparam logic [15:0] SECTOR_MASK    = 16'hfffc; // Sector of two words
    localparam logic [22:0] SECURITY_ADDR  = 23'h7fff0f; // Security byte address
    localparam logic [1:0]  LOCKED_STATE   = 2'h3;    // Secured default state
    localparam logic [15:0] ERASED_WORD    = 16'hffff; // Erased content
    localparam int          CLK_MHZ        = 100;     // System clock rate
    localparam int          OP_TIME_NS     = 200;     // Array operation time per step
    localparam int          OP_CYCLES      = (OP_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam logic [7:0]  OP_COUNT       = 8'(OP_CYCLES);

    // Error flags reported for one command
    typedef struct packed {
        logic access_error;
        logic protection_violation;
        logic verify_bit1;
        logic verify_bit0;
    } dfcs_status_t;

    // Array port towards the flash macro
    typedef struct packed {
        logic        prog;
        logic        erase;
        logic        read;
        logic [15:0] addr;
        logic [15:0] data;
    } dfcs_array_req_t;
endpackage : dfcs_pkg

// *** hdl/dfcs_param_word.sv ***
// One parameter word cell of the command parameter array.
// Assumes write strobes come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module dfcs_param_word
    import dfcs_pkg::*;
#(
    parameter logic [2:0] INDEX = 3'h0  // Index this cell answers to
) (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Write side
    input  wire logic        wr_i,
    input  wire logic [2:0]  idx_i,
    input  wire logic [15:0] data_i,
    // Stored word
    output logic      [15:0] word_o
);
    logic        hit;     // This cell is addressed
    logic [15:0] word_r;  // Stored value

    assign hit    = wr_i && (idx_i == INDEX);
    assign word_o = word_r;

    // Store on write, clear on reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            word_r <= '0;
        end else if (hit) begin
            word_r <= data_i;
        end
    end
endmodule // dfcs_param_word
`default_nettype wire

// *** hdl/dfcs_sequencer.sv ***
// Data flash command sequencer: launch checks, program, erase, verify, status.
// Assumes software writes parameters on the system clock and a flash macro
// answers reads combinationally with data and ECC fault indications.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// R01: Software loads program code, address, data words.
// R02: Index at launch sets one to four words.
// R03: Program with index below two is refused.
// R04: Program with index above five is refused.
// R05: Odd word address gives access error.
// R06: Word range past block end gives error.
// R07: Address outside valid location gives error.
// R08: Command barred by mode or security errors.
// R09: Protected area sets violation, skips work.
// R10: Any verify error sets verify bit one.
// R11: Uncorrectable verify error sets bit zero.
// R12: Program reads words back before completing.
// R13: Software programs only erased words once.
// R14: Software loads erase code and sector address.
// R15: Erase with index not one is refused.
// R16: Erase whole sector, verify, then complete.
// R17: Clearing complete flag launches; set when done.
// R18: Command irq is flag and enable.
// R19: Error irq from fault flags and enables.
// R20: Wait mode leaves operation running normally.
// R21: Stop waits for running command to finish.
// R22: Reset loads security from configuration byte.
// R23: New security byte acts after next reset.
// R24: Flag clear during init; writes ignored.
// R25: Reset aborts a running command at once.
// R26: Interrupt requests are levels until cleared.
// R27: Launch errors leave array, set flag again.
module dfcs_sequencer
    import dfcs_pkg::*;
(
    // Clock and reset
    input  wire logic            SYS_CLK_I,
    input  wire logic            RST_I,
    // Parameter array access
    input  wire logic            PARAM_INDEX_WR_I,
    input  wire logic [2:0]      PARAM_INDEX_I,
    input  wire logic            PARAM_WORD_WR_I,
    input  wire logic [15:0]     PARAM_WORD_I,
    input  wire logic            LAUNCH_I,          // Write one to clear complete flag
    input  wire logic            STATUS_CLR_I,      // Write one to clear error flags
    // Configuration
    input  wire logic            CMD_IRQ_EN_I,
    input  wire logic            DFAULT_IRQ_EN_I,
    input  wire logic            SFAULT_IRQ_EN_I,
    input  wire logic            FAULT_CLR_I,       // Clears both fault flags
    input  wire logic            CMD_ALLOWED_I,     // Mode and security permit
    input  wire logic            DF_PROTECTED_I,    // Protection of target area
    input  wire logic            STOP_REQ_I,
    // Flash macro
    output dfcs_array_req_t      ARRAY_REQ_O,
    input  wire logic [15:0]     ARRAY_RDATA_I,
    input  wire logic            ARRAY_SFAULT_I,
    input  wire logic            ARRAY_DFAULT_I,
    // Status
    output logic [2:0]           PARAM_INDEX_O,
    output logic                 CMD_COMPLETE_O,
    output dfcs_status_t         STATUS_O,
    output logic                 DFAULT_FLAG_O,
    output logic                 SFAULT_FLAG_O,
    output logic [7:0]           SECURITY_O,
    output logic [1:0]           SECURITY_STATE_O,
    output logic                 STOP_ACK_O,
    output logic                 CMD_IRQ_O,
    output logic                 ERR_IRQ_O
);
    typedef enum logic [2:0] {
        ST_INIT, ST_IDLE, ST_CHECK, ST_ERASE, ST_PROG, ST_VERIFY, ST_DONE
    } dfcs_state_t;

    dfcs_state_t     state_r, state_nxt;   // Sequencer state
    logic [2:0]      idx_r;                // Parameter index
    logic [2:0]      launch_idx_r;         // Index captured at launch
    logic            complete_r;           // Command complete flag
    dfcs_status_t    status_r;             // Error and verify flags
    logic            dfault_r, sfault_r;   // ECC fault flags
    logic [7:0]      security_r;           // Security register
    logic [7:0]      timer_r;              // Step timer
    logic [1:0]      step_r;               // Word within operation
    logic [15:0]     words [PARAM_DEPTH];  // Parameter array
    logic            sync_d1_r, sync_d2_r; // Stop request synchroniser

    // Decoded command fields
    logic [7:0]  cmd_code;
    logic [6:0]  blk_sel;
    logic [15:0] base_addr;
    logic [2:0]  n_words;
    logic [15:0] end_addr;
    logic        is_prog, is_erase, acc_err, op_step_done, last_step;
    logic [15:0] cur_addr;

    assign cmd_code  = words[IDX_CMD][15:8];
    assign blk_sel   = words[IDX_CMD][6:0];
    assign base_addr = (is_erase) ? (words[IDX_ADDR] & SECTOR_MASK) : words[IDX_ADDR];
    assign is_prog   = (cmd_code == CMD_PROGRAM);
    assign is_erase  = (cmd_code == CMD_ERASE);
    // Count of words from the launch index; range is checked separately
    assign n_words   = 3'(launch_idx_r - IDX_DATA_FIRST + 3'h1);               // see R02
    assign end_addr  = 16'(words[IDX_ADDR] + {12'h000, n_words, 1'b0} - 16'h1);

    // Launch-time access error checks
    assign acc_err =
        (!is_prog && !is_erase) ||
        (is_prog  && (launch_idx_r < IDX_DATA_FIRST)) ||                       // see R03
        (is_prog  && (launch_idx_r > IDX_DATA_LAST)) ||                        // see R04
        (is_erase && (launch_idx_r != IDX_ADDR)) ||                            // see R15
        words[IDX_ADDR][0] ||                                                  // see R05
        (is_prog  && (end_addr > DF_LAST || end_addr < words[IDX_ADDR])) ||    // see R06
        (blk_sel != DF_BLOCK_SEL) || (words[IDX_ADDR] > DF_LAST) ||            // see R07
        !CMD_ALLOWED_I;                                                        // see R08

    assign op_step_done = (timer_r == OP_COUNT);
    assign last_step    = is_erase ? (step_r == 2'h1) : (3'({1'b0, step_r}) == 3'(n_words - 3'h1));
    assign cur_addr     = 16'(base_addr + {13'h0000, step_r, 1'b0});

    // Parameter array cells; writes held off while a command runs
    for (genvar g = 0; g < PARAM_DEPTH; g++) begin : g_param
        dfcs_param_word #(.INDEX(3'(g))) u_word (
            .clk_i  (SYS_CLK_I),
            .rst_i  (RST_I),
            .wr_i   (PARAM_WORD_WR_I && complete_r),                           // see R24
            .idx_i  (idx_r),
            .data_i (PARAM_WORD_I),
            .word_o (words[g])
        );
    end

    // Next state
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_INIT:   state_nxt = ST_IDLE;                                    // see R22
            ST_IDLE:   if (LAUNCH_I && complete_r) state_nxt = ST_CHECK;       // see R17
            ST_CHECK: begin
                if (acc_err || DF_PROTECTED_I) begin
                    state_nxt = ST_DONE;                                       // see R27
                end else if (is_erase) begin
                    state_nxt = ST_ERASE;
                end else begin
                    state_nxt = ST_PROG;
                end
            end
            ST_ERASE:  if (op_step_done && last_step) state_nxt = ST_VERIFY;   // see R16
            ST_PROG:   if (op_step_done && last_step) state_nxt = ST_VERIFY;
            ST_VERIFY: if (last_step) state_nxt = ST_DONE;                     // see R12
            ST_DONE:   state_nxt = ST_IDLE;
        endcase
    end

    // State register; reset aborts any command at once
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            state_r <= ST_INIT;                                                // see R25
        end else begin
            state_r <= state_nxt;
        end
    end

    // Step timer and word counter
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I || state_r == ST_CHECK) begin
            timer_r <= '0;
            step_r  <= '0;
        end else if (state_r == ST_VERIFY) begin
            step_r  <= last_step ? 2'h0 : 2'(step_r + 2'h1);
        end else if (state_r == ST_ERASE || state_r == ST_PROG) begin
            timer_r <= op_step_done ? 8'h00 : 8'(timer_r + 8'h01);
            if (op_step_done) step_r <= last_step ? 2'h0 : 2'(step_r + 2'h1);
        end
    end

    // Parameter index and launch capture
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            idx_r        <= '0;
            launch_idx_r <= '0;
        end else begin
            if (PARAM_INDEX_WR_I && complete_r) idx_r <= PARAM_INDEX_I;        // see R24
            if (state_r == ST_IDLE) launch_idx_r <= idx_r;                     // see R02
        end
    end

    // Complete flag: clear in init and while running, set when finished
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            complete_r <= 1'b0;                                                // see R24
        end else if (state_r == ST_INIT || state_r == ST_DONE) begin
            complete_r <= 1'b1;                                                // see R17
        end else if (state_r == ST_IDLE && LAUNCH_I) begin
            complete_r <= 1'b0;
        end
    end

    // Error and verify flags; a new launch starts them afresh
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            status_r <= '0;
        end else if (state_r == ST_CHECK) begin
            status_r.access_error         <= acc_err;
            status_r.protection_violation <= !acc_err && DF_PROTECTED_I;       // see R09
            status_r.verify_bit1          <= 1'b0;
            status_r.verify_bit0          <= 1'b0;
        end else if (state_r == ST_VERIFY) begin
            if (ARRAY_SFAULT_I || ARRAY_DFAULT_I || ARRAY_RDATA_I != (is_erase ?
                ERASED_WORD : words[3'(IDX_DATA_FIRST + {1'b0, step_r})]))
                status_r.verify_bit1 <= 1'b1;                                  // see R10
            if (ARRAY_DFAULT_I) status_r.verify_bit0 <= 1'b1;                  // see R11
        end else if (STATUS_CLR_I && state_r == ST_IDLE) begin
            status_r.access_error         <= 1'b0;
            status_r.protection_violation <= 1'b0;
        end
    end

    // ECC fault flags: set wins over clear
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            dfault_r <= 1'b0;
            sfault_r <= 1'b0;
        end else begin
            dfault_r <= (state_r == ST_VERIFY && ARRAY_DFAULT_I) || (dfault_r && !FAULT_CLR_I);
            sfault_r <= (state_r == ST_VERIFY && ARRAY_SFAULT_I) || (sfault_r && !FAULT_CLR_I);
        end
    end

    // Security loaded only during init, so reprogramming acts after next reset
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            security_r <= {6'h3f, LOCKED_STATE};
        end else if (state_r == ST_INIT) begin
            security_r <= ARRAY_RDATA_I[7:0];                                  // see R22, R23
        end
    end

    // Stop request synchroniser
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            sync_d1_r <= 1'b0;
            sync_d2_r <= 1'b0;
        end else begin
            sync_d1_r <= STOP_REQ_I;
            sync_d2_r <= sync_d1_r;
        end
    end

    // Array requests; init reads the security byte
    assign ARRAY_REQ_O.prog  = (state_r == ST_PROG);
    assign ARRAY_REQ_O.erase = (state_r == ST_ERASE);
    assign ARRAY_REQ_O.read  = (state_r == ST_VERIFY) || (state_r == ST_INIT);
    assign ARRAY_REQ_O.addr  = (state_r == ST_INIT) ? SECURITY_ADDR[15:0] : cur_addr;
    assign ARRAY_REQ_O.data  = words[3'(IDX_DATA_FIRST + {1'b0, step_r})];

    // Status and interrupt outputs; wait mode has no effect on any of this
    assign PARAM_INDEX_O    = idx_r;
    assign CMD_COMPLETE_O   = complete_r;
    assign STATUS_O         = status_r;
    assign DFAULT_FLAG_O    = dfault_r;
    assign SFAULT_FLAG_O    = sfault_r;
    assign SECURITY_O       = security_r;
    assign SECURITY_STATE_O = security_r[1:0];
    assign STOP_ACK_O       = sync_d2_r && complete_r;                         // see R21
    assign CMD_IRQ_O        = complete_r && CMD_IRQ_EN_I;                      // see R18, R20, R26
    assign ERR_IRQ_O        = (dfault_r && DFAULT_IRQ_EN_I) ||
                              (sfault_r && SFAULT_IRQ_EN_I);                   // see R19, R26

    // Complete flag stays low from launch until the done state
    cmd_busy_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I) // see R17
        (state_r inside {ST_CHECK, ST_ERASE, ST_PROG, ST_VERIFY}) |-> !complete_r)
        else $error("complete flag high while busy");
    launch_err_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I) // see R27
        (state_r == ST_CHECK && acc_err) |=> (state_r == ST_DONE) ##1 complete_r)
        else $error("launch error not completed at once");
    idx_low_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I) // see R03
        (state_r == ST_CHECK && is_prog && launch_idx_r < IDX_DATA_FIRST)
        |=> status_r.access_error && !ARRAY_REQ_O.prog)
        else $error("low index program not refused");
    idx_high_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I) // see R04
        (state_r == ST_CHECK && is_prog && launch_idx_r > IDX_DATA_LAST)
        |=> status_r.access_error)
        else $error("high index program not refused");
    erase_idx_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I) // see R15
        (state_r == ST_CHECK && is_erase && launch_idx_r != IDX_ADDR) |=> status_r.access_error)
        else $error("erase index not refused");
    protect_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I) // see R09
        (state_r == ST_CHECK && !acc_err && DF_PROTECTED_I)
        |=> status_r.protection_violation && !ARRAY_REQ_O.erase && !ARRAY_REQ_O.prog)
        else $error("protected area touched");
    cmd_irq_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I) // see R18
        (state_r == ST_DONE) |=> (CMD_IRQ_O == CMD_IRQ_EN_I))
        else $error("command irq mismatch");
    stop_hold_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I) // see R21
        (state_r inside {ST_CHECK, ST_ERASE, ST_PROG, ST_VERIFY}) |-> !STOP_ACK_O)
        else $error("stop allowed while busy");
    verify_fault_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I) // see R11
        (state_r == ST_VERIFY && ARRAY_DFAULT_I) |=> status_r.verify_bit0 && status_r.verify_bit1)
        else $error("uncorrectable fault not reported");
endmodule // dfcs_sequencer
`default_nettype wire

// *** tb/dfcs_tb_top.sv ***
// Self-checking bench for the data flash command sequencer.
// Assumes dfcs_pkg is compiled first; the bench plays software and the flash array.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin mismatches++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, (a), (b)); end end
module data_flash_command_sequencer_tb_top import dfcs_pkg::*;;
    // Stimulus driven by the bench
    logic            clk = 1'b0;     // System clock
    logic            rst = 1'b1;     // Synchronous reset
    logic            idx_wr = 1'b0;  // Index write strobe
    logic            word_wr = 1'b0; // Word write strobe
    logic            launch = 1'b0;  // Launch strobe
    logic            st_clr = 1'b0;  // Error flag clear
    logic            f_clr = 1'b0;   // Fault flag clear
    logic [2:0]      idx = 3'h0;
    logic [15:0]     word = 16'h0000;
    logic            cmd_en = 1'b1;
    logic            df_en = 1'b0;
    logic            sf_en = 1'b0;
    logic            allowed = 1'b1;
    logic            prot = 1'b0;
    logic            stop = 1'b0;
    logic            sf = 1'b0;      // Inject single fault on reads
    logic            df = 1'b0;      // Inject double fault on reads
    logic [7:0]      lock_byte = 8'h82; // Stored security byte
    // Flash array model and design outputs
    logic [15:0]     mem [0:2047];
    logic [15:0]     rdata;
    dfcs_array_req_t req;
    dfcs_status_t    st;
    logic [2:0]      idx_o;
    logic            cc, dflag, sflag, stop_ack, cirq, eirq;
    logic [7:0]      lock_reg;
    logic [1:0]      lock_state;
    int              mismatches = 0;
    int              checks_done = 0;
    int              n;

    // Clock at 100 MHz
    always #5 clk = ~clk;

    // Security byte lives outside the data block, so it is decoded first
    assign rdata = (req.addr == 16'hff0f) ? {8'h00, lock_byte} : mem[req.addr[11:1]];

    // Array model: programming can only clear bits, erase covers a two-word sector
    always @(posedge clk) begin
        if (req.prog) begin
            mem[req.addr[11:1]] <= mem[req.addr[11:1]] & req.data;
        end
        if (req.erase) begin
            mem[{req.addr[11:2], 1'b0}] <= 16'hffff;
            mem[{req.addr[11:2], 1'b1}] <= 16'hffff;
        end
    end

    dfcs_sequencer uut (
        .SYS_CLK_I(clk), .RST_I(rst),
        .PARAM_INDEX_WR_I(idx_wr), .PARAM_INDEX_I(idx),
        .PARAM_WORD_WR_I(word_wr), .PARAM_WORD_I(word),
        .LAUNCH_I(launch), .STATUS_CLR_I(st_clr),
        .CMD_IRQ_EN_I(cmd_en), .DFAULT_IRQ_EN_I(df_en), .SFAULT_IRQ_EN_I(sf_en),
        .FAULT_CLR_I(f_clr), .CMD_ALLOWED_I(allowed), .DF_PROTECTED_I(prot),
        .STOP_REQ_I(stop), .ARRAY_REQ_O(req), .ARRAY_RDATA_I(rdata),
        .ARRAY_SFAULT_I(sf & req.read), .ARRAY_DFAULT_I(df & req.read),
        .PARAM_INDEX_O(idx_o), .CMD_COMPLETE_O(cc), .STATUS_O(st),
        .DFAULT_FLAG_O(dflag), .SFAULT_FLAG_O(sflag), .SECURITY_O(lock_reg),
        .SECURITY_STATE_O(lock_state), .STOP_ACK_O(stop_ack),
        .CMD_IRQ_O(cirq), .ERR_IRQ_O(eirq)
    );

    // Inputs always move 1 ns after the rising edge
    task automatic tick();
        @(posedge clk);
        #1;
    endtask

    // Set the parameter index
    task automatic setidx(input logic [2:0] i);
        tick();
        idx_wr = 1'b1;
        idx = i;
        tick();
        idx_wr = 1'b0;
    endtask

    // Write one parameter word at a given index
    task automatic put(input logic [2:0] i, input logic [15:0] w);
        setidx(i);
        word_wr = 1'b1;
        word = w;
        tick();
        word_wr = 1'b0;
    endtask

    // Launch and wait for completion under a bound
    task automatic go(output int cyc);
        tick();
        launch = 1'b1;
        tick();
        launch = 1'b0;
        `CHK(cc, 1'b0)
        `CHK(stop_ack, 1'b0)
        `CHK(cirq, 1'b0)
        cyc = 0;
        while (cc !== 1'b1 && cyc < 400) begin
            tick();
            cyc++;
        end
        `CHK(cc, 1'b1)
        `CHK(cirq, cmd_en)
    endtask

    // Full command: code, block, address, data words, final index
    task automatic op(input logic [7:0] c, input logic [6:0] b, input logic [15:0] a,
                      input logic [2:0] li, input logic [3:0] es, output int cyc);
        for (int i = 0; i < 6; i++) begin
            put(i[2:0], (i == 0) ? {c, 1'b0, b} : ((i == 1) ? a : 16'h5a00 | 16'(i)));
        end
        setidx(li);
        go(cyc);
        `CHK(st, es)
    endtask

    // Checksum of the whole array, to prove it was left alone
    function automatic logic [15:0] msum();
        logic [15:0] s;
        s = 16'h0000;
        for (int i = 0; i < 2048; i++) begin
            s = s ^ mem[i] ^ 16'(i);
        end
        return s;
    endfunction

    // Refused command: array unchanged, quick completion for access errors
    task automatic err(input logic [7:0] c, input logic [6:0] b, input logic [15:0] a,
                       input logic [2:0] li, input logic [3:0] es);
        logic [15:0] s;
        s = msum();
        op(c, b, a, li, es, n);
        `CHK(msum(), s)
        if (es == 4'h8) begin
            `CHK(n <= 3, 1'b1)
        end
    endtask

    task automatic done(input string s);
        $display("test %s finished", s);
    endtask

    // Single place where the run ends
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Watchdog well beyond the fewer than a thousand cycles the tests need
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        end_sim();
    end

    // Main sequence
    initial begin
        for (int i = 0; i < 2048; i++) begin
            mem[i] = (i >= 1 && i <= 4) ? 16'h0000 : 16'hffff;
        end
        repeat (3) tick();
        `CHK(cc, 1'b0)
        repeat (3) tick();
        rst = 1'b0;
        n = 0;
        while (cc !== 1'b1 && n < 50) begin
            tick();
            n++;
        end
        `CHK(cc, 1'b1)
        `CHK(lock_reg, lock_byte)
        `CHK(lock_state, lock_byte[1:0])
        done("reset");
        // Erase with stop pending: stop is granted only once idle
        stop = 1'b1;
        op(CMD_ERASE, DF_BLOCK_SEL, 16'h0006, IDX_ADDR, 4'h0, n);
        `CHK({mem[1], mem[2], mem[3], mem[4]}, 64'h0000_ffff_ffff_0000)
        repeat (3) tick();
        `CHK(stop_ack, 1'b1)
        `CHK(cirq, 1'b1)
        stop = 1'b0;
        done("erase");
        // Four words, with an index write attempted while busy
        fork
            op(CMD_PROGRAM, DF_BLOCK_SEL, 16'h0010, IDX_DATA_LAST, 4'h0, n);
            begin
                repeat (60) tick();
                setidx(3'h7);
            end
        join
        `CHK(idx_o, IDX_DATA_LAST)
        `CHK(n >= 4 * OP_CYCLES, 1'b1)
        `CHK({mem[8], mem[9], mem[10], mem[11], mem[12]}, 80'h5a02_5a03_5a04_5a05_ffff)
        op(CMD_PROGRAM, DF_BLOCK_SEL, 16'h0020, IDX_DATA_FIRST, 4'h0, n);
        `CHK({mem[16], mem[17]}, 32'h5a02_ffff)
        op(CMD_PROGRAM, DF_BLOCK_SEL, 16'h0ffc, 3'h3, 4'h0, n);
        `CHK({mem[2046], mem[2047]}, 32'h5a02_5a03)
        done("program");
        // Launch-time refusals
        err(CMD_PROGRAM, DF_BLOCK_SEL, 16'h0100, 3'h1, 4'h8);
        err(CMD_PROGRAM, DF_BLOCK_SEL, 16'h0100, 3'h0, 4'h8);
        err(CMD_PROGRAM, DF_BLOCK_SEL, 16'h0100, 3'h6, 4'h8);
        err(CMD_PROGRAM, DF_BLOCK_SEL, 16'h0100, 3'h7, 4'h8);
        err(CMD_PROGRAM, DF_BLOCK_SEL, 16'h0101, 3'h2, 4'h8);
        err(CMD_ERASE, DF_BLOCK_SEL, 16'h0101, 3'h1, 4'h8);
        err(CMD_PROGRAM, DF_BLOCK_SEL, 16'h0ffe, 3'h3, 4'h8);
        err(CMD_PROGRAM, 7'h11, 16'h0100, 3'h2, 4'h8);
        err(CMD_ERASE, 7'h11, 16'h0100, 3'h1, 4'h8);
        err(CMD_PROGRAM, DF_BLOCK_SEL, 16'h1000, 3'h2, 4'h8);
        err(CMD_ERASE, DF_BLOCK_SEL, 16'h0100, 3'h2, 4'h8);
        err(CMD_ERASE, DF_BLOCK_SEL, 16'h0100, 3'h0, 4'h8);
        allowed = 1'b0;
        err(CMD_PROGRAM, DF_BLOCK_SEL, 16'h0100, 3'h2, 4'h8);
        err(CMD_ERASE, DF_BLOCK_SEL, 16'h0100, 3'h1, 4'h8);
        allowed = 1'b1;
        prot = 1'b1;
        err(CMD_PROGRAM, DF_BLOCK_SEL, 16'h0100, 3'h2, 4'h4);
        err(CMD_ERASE, DF_BLOCK_SEL, 16'h0100, 3'h1, 4'h4);
        prot = 1'b0;
        tick();
        st_clr = 1'b1;
        tick();
        st_clr = 1'b0;
        `CHK(st, 4'h0)
        done("refusals");
        // Verify faults and the error request
        cmd_en = 1'b0;
        sf = 1'b1;
        sf_en = 1'b1;
        op(CMD_PROGRAM, DF_BLOCK_SEL, 16'h0200, IDX_DATA_FIRST, 4'h2, n);
        sf = 1'b0;
        `CHK({sflag, dflag, eirq, cirq}, 4'b1010)
        sf_en = 1'b0;
        tick();
        `CHK(eirq, 1'b0)
        df = 1'b1;
        op(CMD_ERASE, DF_BLOCK_SEL, 16'h0300, IDX_ADDR, 4'h3, n);
        df = 1'b0;
        df_en = 1'b1;
        repeat (5) tick();
        `CHK({dflag, eirq}, 2'b11)
        tick();
        f_clr = 1'b1;
        tick();
        f_clr = 1'b0;
        `CHK({sflag, dflag, eirq}, 3'b000)
        done("faults");
        // Reset in mid-program; new security byte is seen only after it
        cmd_en = 1'b1;
        for (int i = 0; i < 6; i++) begin
            put(i[2:0], (i == 0) ? {CMD_PROGRAM, 1'b0, DF_BLOCK_SEL} : 16'h0400);
        end
        setidx(IDX_DATA_LAST);
        tick();
        launch = 1'b1;
        tick();
        launch = 1'b0;
        lock_byte = 8'h41;
        repeat (10) tick();
        `CHK(req.prog, 1'b1)
        `CHK(lock_reg, 8'h82)
        rst = 1'b1;
        tick();
        `CHK({req.prog, cc}, 2'b00)
        repeat (5) tick();
        rst = 1'b0;
        repeat (10) tick();
        `CHK(cc, 1'b1)
        `CHK({lock_reg, lock_state}, 10'h105)
        done("reset abort");
        end_sim();
    end
endmodule // data_flash_command_sequencer_tb_top
`undef CHK
`default_nettype wire
